// ---- hdl/reset_sync_three_phase_pwm.sv ----
// Purpose: Reset-synchronous three-phase PWM timer with AHB-Lite registers
// Assumes: hclk at 200 MHz is the operation clock; pins and fast osc are asynchronous
// Notes:   Zero-wait slave; read data valid in the data phase after address phase
`timescale 1ns/100ps

module reset_sync_three_phase_pwm
	import rspwm_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        fast_osc_clock,
	input  wire logic        cutoff_interrupt_pin,
	input  wire timer_pins_s pin_in,
	output timer_pins_s      pin_out,
	output timer_pins_s      pin_oe,
	output logic             count_running
);

	// Bus phase registers
	logic        wr_pend;
	logic [7:0]  wr_addr;
	// Control and data registers
	run_state_e  run_state;
	logic        stop_select_bit;
	logic [7:0]  mode;
	logic [3:0]  level;
	logic [7:0]  output_disable_bits;
	logic [NUM_FLAGS-1:0] flags;
	logic [15:0] channel0_counter;
	logic [15:0] period_compare;
	logic [15:0] duty_compare_out1;
	logic [15:0] duty_compare_out2;
	logic [15:0] duty_compare_out3;
	logic [15:0] buffer_c_ch0;
	logic [15:0] buffer_d_ch0;
	logic [15:0] buffer_c_ch1;
	logic [15:0] buffer_d_ch1;
	// Count source logic
	logic [PSC_WIDTH-1:0] psc;
	logic [2:0]  ext_sync;
	logic [2:0]  osc_sync;
	logic [1:0]  cut_sync;
	logic        tick;
	// Waveform state
	logic [2:0]  norm_act;
	logic        toggle;
	// Decodes
	logic        wr_start;
	logic        wr_level;
	logic        counting;
	logic        period_hit;
	logic [NUM_FLAGS-1:0] hits;
	logic [NUM_FLAGS-1:0] clr_mask;
	logic        cut_now;
	logic [15:0] duty [3];

	assign hreadyout     = 1'b1;
	assign hresp         = 1'b0;
	assign count_running = (run_state != ST_IDLE);

	// Address phase capture
	// Write address held for the data phase, when hwdata stands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (hready) begin
			wr_pend <= hsel && htrans[1] && hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	assign wr_start = wr_pend && (wr_addr == OFF_START);
	assign wr_level = wr_pend && (wr_addr == OFF_LEVEL);

	// Read data, registered at the address phase
	// A read straight after a write address phase sees the old value
	// Zero wait states, so hreadyout stays high
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				OFF_START:   hrdata <= {30'h0, stop_select_bit, count_running};
				OFF_MODE:    hrdata <= {24'h000000, mode};
				OFF_LEVEL:   hrdata <= {28'h0000000, level};
				OFF_DISABLE: hrdata <= {24'h000000, output_disable_bits};
				OFF_STATUS:  hrdata <= {25'h0, flags};
				OFF_COUNT:   hrdata <= {16'h0000, channel0_counter};
				OFF_PERIOD:  hrdata <= {16'h0000, period_compare};
				OFF_DUTY1:   hrdata <= {16'h0000, duty_compare_out1};
				OFF_DUTY2:   hrdata <= {16'h0000, duty_compare_out2};
				OFF_DUTY3:   hrdata <= {16'h0000, duty_compare_out3};
				OFF_BUFC0:   hrdata <= {16'h0000, buffer_c_ch0};
				OFF_BUFD0:   hrdata <= {16'h0000, buffer_d_ch0};
				OFF_BUFC1:   hrdata <= {16'h0000, buffer_c_ch1};
				OFF_BUFD1:   hrdata <= {16'h0000, buffer_d_ch1};
				default:     hrdata <= 32'h00000000;
			endcase
		end
	end

	// Synchronisers for asynchronous inputs; third stage only for edges
	// Only the second and third stages feed logic, avoiding metastable reads
	// Cutoff stage resets high, the idle level of its pin
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_sync <= 3'h0;
			osc_sync <= 3'h0;
			cut_sync <= 2'h3;
		end else begin
			ext_sync <= {ext_sync[1:0], pin_in.ch0_pin_a};
			osc_sync <= {osc_sync[1:0], fast_osc_clock};
			cut_sync <= {cut_sync[0], cutoff_interrupt_pin};
		end
	end

	// Free-running divider for internal sources
	// Low bits all ones give the divided tick
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			psc <= '0;
		end else begin
			psc <= psc + 1'b1;
		end
	end

	// Count source selection
	// External edges need levels of more than one clock
	// Reserved codes give no tick, so the counter waits
	always_comb begin
		case (count_src_e'(mode[MODE_SRC_LSB +: 3]))
			SRC_F1:   tick = 1'b1;
			SRC_F2:   tick = psc[0];
			SRC_F4:   tick = &psc[1:0];
			SRC_F8:   tick = &psc[2:0];
			SRC_F32:  tick = &psc[4:0];
			SRC_FOSC: tick = osc_sync[1] && !osc_sync[2];
			SRC_EXT: begin
				if (!mode[BIT_EXT_EN])
					tick = 1'b0;
				else if (mode[MODE_EDGE_LSB +: 2] == EDGE_RISE)
					tick = ext_sync[1] && !ext_sync[2];
				else if (mode[MODE_EDGE_LSB +: 2] == EDGE_FALL)
					tick = !ext_sync[1] && ext_sync[2];
				else
					tick = ext_sync[1] ^ ext_sync[2];
			end
			default:  tick = 1'b0;
		endcase
	end

	assign counting   = count_running && tick;
	assign period_hit = counting && (channel0_counter == period_compare);
	assign duty[0]    = duty_compare_out1;
	assign duty[1]    = duty_compare_out2;
	assign duty[2]    = duty_compare_out3;

	// Run state: start, immediate stop or stop at period match
	// Draining keeps counting until the period match clears the count
	// Stop-select one leaves the pins at their last levels
	// A run write while draining resumes without a stop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_state       <= ST_IDLE;
			stop_select_bit <= 1'b0;
		end else begin
			if (wr_start)
				stop_select_bit <= hwdata[BIT_CSEL];
			case (run_state)
				ST_IDLE: begin
					if (wr_start && hwdata[BIT_RUN])
						run_state <= ST_RUNNING;
				end
				ST_RUNNING: begin
					if (wr_start && !hwdata[BIT_RUN] && hwdata[BIT_CSEL])
						run_state <= ST_IDLE;
					else if (wr_start && !hwdata[BIT_RUN])
						run_state <= ST_DRAINING;
				end
				ST_DRAINING: begin
					if (wr_start && hwdata[BIT_RUN])
						run_state <= ST_RUNNING;
					else if (wr_start && hwdata[BIT_CSEL])
						run_state <= ST_IDLE;
					else if (period_hit)
						run_state <= ST_IDLE;
				end
				default: run_state <= ST_IDLE;
			endcase
		end
	end

	// Channel 0 counter; a software load wins over a count
	// Period match wraps to zero; the 16-bit add wraps past the top
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			channel0_counter <= 16'h0000;
		end else if (wr_pend && wr_addr == OFF_COUNT) begin
			channel0_counter <= hwdata[15:0];
		end else if (period_hit) begin
			channel0_counter <= 16'h0000;
		end else if (counting) begin
			channel0_counter <= channel0_counter + 16'h0001;
		end
	end

	// Compare and buffer registers; buffer transfer at period match
	// Buffer copy beats a bus write to the same compare
	// Copying only at the wrap keeps each period consistent
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			period_compare    <= CMP_RESET;
			duty_compare_out1 <= CMP_RESET;
			duty_compare_out2 <= CMP_RESET;
			duty_compare_out3 <= CMP_RESET;
			buffer_c_ch0      <= CMP_RESET;
			buffer_d_ch0      <= CMP_RESET;
			buffer_c_ch1      <= CMP_RESET;
			buffer_d_ch1      <= CMP_RESET;
		end else begin
			if (period_hit && mode[BIT_BUF_EN]) begin
				period_compare    <= buffer_c_ch0;
				duty_compare_out1 <= buffer_d_ch0;
				duty_compare_out2 <= buffer_c_ch1;
				duty_compare_out3 <= buffer_d_ch1;
			end else if (wr_pend) begin
				case (wr_addr)
					OFF_PERIOD: period_compare    <= hwdata[15:0];
					OFF_DUTY1:  duty_compare_out1 <= hwdata[15:0];
					OFF_DUTY2:  duty_compare_out2 <= hwdata[15:0];
					OFF_DUTY3:  duty_compare_out3 <= hwdata[15:0];
					default: ;
				endcase
			end
			if (wr_pend) begin
				case (wr_addr)
					OFF_BUFC0: buffer_c_ch0 <= hwdata[15:0];
					OFF_BUFD0: buffer_d_ch0 <= hwdata[15:0];
					OFF_BUFC1: buffer_c_ch1 <= hwdata[15:0];
					OFF_BUFD1: buffer_d_ch1 <= hwdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// Mode and level registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode  <= MODE_RESET;
			level <= LEVEL_RESET;
		end else if (wr_pend && wr_addr == OFF_MODE) begin
			mode <= hwdata[7:0];
		end else if (wr_level) begin
			level <= hwdata[3:0];
		end
	end

	// Match and overflow events
	// Overflow only when the wrap is not a period match
	always_comb begin
		hits               = '0;
		hits[FLG_MATCH_A0] = counting && (channel0_counter == period_compare);
		hits[FLG_MATCH_B0] = counting && (channel0_counter == duty_compare_out1);
		hits[FLG_MATCH_C0] = counting && (channel0_counter == buffer_c_ch0);
		hits[FLG_MATCH_D0] = counting && (channel0_counter == buffer_d_ch0);
		hits[FLG_MATCH_A1] = counting && (channel0_counter == duty_compare_out2);
		hits[FLG_MATCH_B1] = counting && (channel0_counter == duty_compare_out3);
		hits[FLG_OVF]      = counting && !period_hit
		                     && (channel0_counter == COUNT_MAX);
	end

	assign clr_mask = (wr_pend && wr_addr == OFF_STATUS) ? hwdata[NUM_FLAGS-1:0] : '0;

	// Sticky flags, write one to clear; a new event wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~clr_mask) | hits;
		end
	end

	// Forced cutoff sets every disable bit; it wins over software
	// Synchroniser adds latency: pin low to drive off in three clocks
	// Software cannot re-enable pins while the pin stays low
	assign cut_now = mode[BIT_CUT_EN] && !cut_sync[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			output_disable_bits <= DISABLE_RESET;
		end else if (cut_now) begin
			output_disable_bits <= DISABLE_RESET;
		end else if (wr_pend && wr_addr == OFF_DISABLE) begin
			output_disable_bits <= hwdata[7:0];
		end
	end

	// Phase state per output; level write loads initial state
	// Duty above the period never matches, so the output stays inactive
	// Period match clears all three at once, the shared reset edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			norm_act <= 3'h0;
			toggle   <= 1'b0;
		end else if (wr_level) begin
			norm_act <= {3{hwdata[BIT_NORM_INIT]}};
			toggle   <= hwdata[BIT_TOG_INIT];
		end else if (period_hit) begin
			norm_act <= 3'h0;
			toggle   <= !toggle;
		end else if (counting) begin
			for (int i = 0; i < 3; i++) begin
				if (channel0_counter == duty[i])
					norm_act[i] <= 1'b1;
			end
		end
	end

	// Pin levels from phase state and active level selection
	// Counter phase is the plain complement, no dead time
	always_comb begin
		pin_out           = '0;
		pin_out.ch0_pin_b = ( norm_act[0]) ~^ level[BIT_NORM_HIGH];
		pin_out.ch0_pin_d = (!norm_act[0]) ~^ level[BIT_CNTR_HIGH];
		pin_out.ch1_pin_a = ( norm_act[1]) ~^ level[BIT_NORM_HIGH];
		pin_out.ch1_pin_c = (!norm_act[1]) ~^ level[BIT_CNTR_HIGH];
		pin_out.ch1_pin_b = ( norm_act[2]) ~^ level[BIT_NORM_HIGH];
		pin_out.ch1_pin_d = (!norm_act[2]) ~^ level[BIT_CNTR_HIGH];
		pin_out.ch0_pin_c = toggle;
	end

	// Drive enables; pin a of channel 0 is input only here
	// Disabled pins fall back to their pull levels outside
	always_comb begin
		pin_oe           = ~output_disable_bits;
		pin_oe.ch0_pin_a = 1'b0;
	end

endmodule : reset_sync_three_phase_pwm

// ---- inc/rspwm_pkg.sv ----
// Purpose: Shared constants and types for the reset-synchronous three-phase PWM timer
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   Offsets are byte addresses
package rspwm_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_START   = 8'h00;
	localparam logic [7:0] OFF_MODE    = 8'h04;
	localparam logic [7:0] OFF_LEVEL   = 8'h08;
	localparam logic [7:0] OFF_DISABLE = 8'h0C;
	localparam logic [7:0] OFF_STATUS  = 8'h10;
	localparam logic [7:0] OFF_COUNT   = 8'h14;
	localparam logic [7:0] OFF_PERIOD  = 8'h18;
	localparam logic [7:0] OFF_DUTY1   = 8'h1C;
	localparam logic [7:0] OFF_DUTY2   = 8'h20;
	localparam logic [7:0] OFF_DUTY3   = 8'h24;
	localparam logic [7:0] OFF_BUFC0   = 8'h28;
	localparam logic [7:0] OFF_BUFD0   = 8'h2C;
	localparam logic [7:0] OFF_BUFC1   = 8'h30;
	localparam logic [7:0] OFF_BUFD1   = 8'h34;

	// start_control_reg fields
	localparam int BIT_RUN  = 0;
	localparam int BIT_CSEL = 1;

	// Mode register fields
	localparam int MODE_SRC_LSB  = 0;
	localparam int MODE_EDGE_LSB = 3;
	localparam int BIT_BUF_EN    = 5;
	localparam int BIT_CUT_EN    = 6;
	localparam int BIT_EXT_EN    = 7;
	localparam logic [7:0] MODE_RESET = 8'h00;

	// Level register fields
	localparam int BIT_NORM_HIGH = 0;
	localparam int BIT_CNTR_HIGH = 1;
	localparam int BIT_NORM_INIT = 2;
	localparam int BIT_TOG_INIT  = 3;
	localparam logic [3:0] LEVEL_RESET = 4'h3;

	// Output disable bits: one per pin, all disabled at reset
	localparam logic [7:0] DISABLE_RESET = 8'hFF;

	// Status flag positions
	localparam int FLG_MATCH_A0 = 0;
	localparam int FLG_MATCH_B0 = 1;
	localparam int FLG_MATCH_C0 = 2;
	localparam int FLG_MATCH_D0 = 3;
	localparam int FLG_MATCH_A1 = 4;
	localparam int FLG_MATCH_B1 = 5;
	localparam int FLG_OVF      = 6;
	localparam int NUM_FLAGS    = 7;

	// Compare reset value, count top and divider width
	localparam logic [15:0] CMP_RESET   = 16'hFFFF;
	localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
	localparam int          PSC_WIDTH   = 5;

	// Count source codes
	typedef enum logic [2:0] {
		SRC_F1   = 3'h0,
		SRC_F2   = 3'h1,
		SRC_F4   = 3'h2,
		SRC_F8   = 3'h3,
		SRC_F32  = 3'h4,
		SRC_EXT  = 3'h5,
		SRC_FOSC = 3'h6
	} count_src_e;

	// External clock active edge
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;

	// Run state, Gray along idle -> running -> draining
	typedef enum logic [1:0] {
		ST_IDLE     = 2'b00,
		ST_RUNNING  = 2'b01,
		ST_DRAINING = 2'b11
	} run_state_e;

	// Timer pins, carried together
	typedef struct packed {
		logic ch0_pin_a;
		logic ch0_pin_b;
		logic ch0_pin_c;
		logic ch0_pin_d;
		logic ch1_pin_a;
		logic ch1_pin_b;
		logic ch1_pin_c;
		logic ch1_pin_d;
	} timer_pins_s;

endpackage : rspwm_pkg

// ---- sim/power_stage_model.sv ----
// Purpose: Power stage and clock source beside the timer pins
// Assumes: Released pins are pulled up
// Notes:   Fault pulls the cutoff line low
`timescale 1ns/100ps
module power_stage_model
	import rspwm_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        ext_run,
	input  wire logic        fault,
	input  wire timer_pins_s pin_out,
	input  wire timer_pins_s pin_oe,
	output timer_pins_s      pin_in,
	output logic             cutoff_n
);
	logic [1:0] div = 2'h0;
	logic       ext_clk = 1'b0;
	// External count clock, four hclk each level
	always @(posedge hclk) begin
		div <= div + 2'h1;
		if (ext_run && div == 2'h3) ext_clk <= ~ext_clk;
	end
	// Wire level from driver and pull-up
	always_comb begin
		pin_in = (pin_out & pin_oe) | ~pin_oe;
		pin_in.ch0_pin_a = ext_clk;
	end
	assign cutoff_n = ~fault;
endmodule : power_stage_model

// ---- sim/reset_sync_three_phase_pwm_assertions.sv ----
// Purpose: Port checks for the three-phase PWM timer
// Assumes: One clock, active-low reset
// Notes:   Shadows mode and level writes
`timescale 1ns/100ps
module reset_sync_three_phase_pwm_assertions
	import rspwm_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	input wire logic        fast_osc_clock,
	input wire logic        cutoff_interrupt_pin,
	input wire timer_pins_s pin_in,
	input wire timer_pins_s pin_out,
	input wire timer_pins_s pin_oe,
	input wire logic        count_running
);
	logic       wr_p;
	logic [7:0] a_p;
	logic       cut_en;
	logic [1:0] lvl;
	logic       lvl_wr;
	logic       rd_a;
	// Write address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_p <= 1'b0;
			a_p  <= 8'h00;
		end else begin
			wr_p <= hsel && hready && htrans[1] && hwrite;
			a_p  <= haddr[7:0];
		end
	end
	// Shadow of cutoff enable and levels
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cut_en <= 1'b0;
			lvl    <= LEVEL_RESET[1:0];
		end else begin
			if (wr_p && a_p == OFF_MODE) cut_en <= hwdata[BIT_CUT_EN];
			if (lvl_wr) lvl <= hwdata[1:0];
		end
	end
	assign lvl_wr = wr_p && a_p == OFF_LEVEL;
	assign rd_a   = hsel && hready && htrans[1] && !hwrite;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Pin, phase and bus relations
	chk_cut_disable: assert property ((cut_en && !cutoff_interrupt_pin) [*3]
		|=> pin_oe == 8'h00) else $error("cutoff missed");
	chk_leg_complement: assert property (
		((pin_out.ch0_pin_b == lvl[0]) != (pin_out.ch0_pin_d == lvl[1]))
		&& ((pin_out.ch1_pin_a == lvl[0]) != (pin_out.ch1_pin_c == lvl[1]))
		&& ((pin_out.ch1_pin_b == lvl[0]) != (pin_out.ch1_pin_d == lvl[1])))
		else $error("phases not complementary");
	chk_stop_hold: assert property (!count_running && !lvl_wr |=> $stable(pin_out))
		else $error("pins moved while stopped");
	chk_toggle_cause: assert property ($changed(pin_out.ch0_pin_c)
		|-> $past(count_running) || $past(lvl_wr)) else $error("toggle while idle");
	chk_pin_a_input: assert property (pin_oe.ch0_pin_a == 1'b0)
		else $error("pin a driven");
	chk_upper_zero: assert property (rd_a && haddr[7:0] >= OFF_COUNT
		|=> hrdata[31:16] == 16'h0000) else $error("upper read bits set");
	chk_unmapped_zero: assert property (rd_a && haddr[7:0] > OFF_BUFD1
		|=> hrdata == 32'h0000_0000) else $error("unmapped read not zero");
	chk_run_start: assert property (wr_p && a_p == OFF_START && hwdata[BIT_RUN]
		|=> count_running) else $error("start ignored");
	chk_reset_quiet: assert property ($rose(hresetn) |-> pin_oe == 8'h00 && !count_running)
		else $error("not quiet after reset");
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or error response");
	// Main scenarios
	cover property (count_running ##1 !count_running);
	cover property (cut_en && !cutoff_interrupt_pin);
	cover property ($changed(pin_out.ch0_pin_c));
endmodule : reset_sync_three_phase_pwm_assertions

// ---- sim/reset_sync_three_phase_pwm_tb.sv ----
// Purpose: Self-checking bench for the three-phase PWM timer
// Assumes: Zero-wait slave, f1 equals hclk
// Notes:   Widths are counted over two PWM periods
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
	$display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module reset_sync_three_phase_pwm_tb
	import rspwm_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [2:0]  hsize = 3'h0;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        fosc = 1'b0;
	logic        cut_n;
	logic        fault = 1'b0;
	logic        ext_run = 1'b0;
	logic        count_running;
	timer_pins_s pin_in;
	timer_pins_s pin_out;
	timer_pins_s pin_oe;
	timer_pins_s hold;
	logic [31:0] q;
	int          err_total = 0;
	int          comparisons = 0;
	int          hi[8];
	int          tg;
	logic [7:0]  srcs[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h85, 8'h8D, 8'h06,
		8'h95, 8'h05};
	int          rate[10] = '{67, 33, 16, 8, 2, 8, 8, 23, 16, 0};
	// Clocks, unrelated in phase
	always #2.5 hclk = ~hclk;
	always #7 fosc = ~fosc;
	reset_sync_three_phase_pwm u_reset_sync_three_phase_pwm (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(),
		.fast_osc_clock(fosc), .cutoff_interrupt_pin(cut_n), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .count_running(count_running));
	power_stage_model u_power_stage_model (.hclk(hclk), .ext_run(ext_run), .fault(fault),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .cutoff_n(cut_n));
	task automatic final_report();
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report
	// Bounded wait for hready
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		if (n >= 40) begin
			err_total++;
			final_report();
		end
	endtask : wait_ready
	// One single AHB-Lite transfer
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		hsize <= 3'h2;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
		#1;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask : rd
	// High samples per pin, toggles of pin c
	task automatic window();
		timer_pins_s prev;
		prev = pin_out;
		hi = '{default: 0};
		tg = 0;
		repeat (20) begin
			@(negedge hclk);
			for (int b = 0; b < 8; b++) hi[b] += pin_out[b];
			tg += int'(pin_out.ch0_pin_c != prev.ch0_pin_c);
			prev = pin_out;
		end
	endtask : window
	// Main sequence
	initial begin
		int n;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rd(OFF_MODE, 32'h0);
		rd(OFF_LEVEL, 32'h3);
		rd(OFF_DISABLE, 32'hFF);
		rd(OFF_PERIOD, 32'hFFFF);
		rd(8'h3C, 32'h0);
		ext_run <= 1'b1;
		foreach (srcs[i]) begin
			wr(OFF_COUNT, 32'h0);
			wr(OFF_MODE, {24'h0, srcs[i]});
			wr(OFF_START, 32'h3);
			repeat (64) @(posedge hclk);
			wr(OFF_START, 32'h2);
			bus(1'b0, OFF_COUNT, 32'h0);
			`CHK(q + 3 > rate[i] && q < rate[i] + 3, 1'b1)
		end
		wr(OFF_MODE, 32'h0);
		wr(OFF_COUNT, 32'h0);
		wr(OFF_PERIOD, 32'h9);
		wr(OFF_DUTY1, 32'h3);
		wr(OFF_DUTY2, 32'h0);
		wr(OFF_DUTY3, 32'h8);
		wr(OFF_DISABLE, 32'h0);
		`CHK(pin_oe, 8'h7F)
		wr(OFF_STATUS, 32'h7F);
		wr(OFF_START, 32'h1);
		repeat (12) @(posedge hclk);
		window();
		`CHK(hi[6], 12)
		`CHK(hi[4], 8)
		`CHK(hi[3], 18)
		`CHK(hi[1], 2)
		`CHK(hi[2], 2)
		`CHK(hi[0], 18)
		`CHK(tg, 2)
		rd(OFF_STATUS, 32'h33);
		wr(OFF_LEVEL, 32'h2);
		repeat (12) @(posedge hclk);
		window();
		`CHK(hi[6], 8)
		`CHK(hi[4], 8)
		wr(OFF_LEVEL, 32'h3);
		wr(OFF_START, 32'h3);
		repeat (7) @(posedge hclk);
		wr(OFF_START, 32'h2);
		hold = pin_out;
		bus(1'b0, OFF_COUNT, 32'h0);
		repeat (15) @(posedge hclk);
		`CHK(pin_out, hold)
		rd(OFF_COUNT, q);
		wr(OFF_COUNT, 32'hFFF0);
		rd(OFF_COUNT, 32'hFFF0);
		wr(OFF_STATUS, 32'h7F);
		wr(OFF_START, 32'h3);
		repeat (40) @(posedge hclk);
		rd(OFF_STATUS, 32'h7F);
		wr(OFF_START, 32'h1);
		wr(OFF_START, 32'h0);
		for (n = 0; count_running !== 1'b0 && n < 30; n++) @(posedge hclk);
		`CHK(n < 30, 1'b1)
		rd(OFF_COUNT, 32'h0);
		`CHK(pin_out.ch0_pin_b, 1'b0)
		`CHK(pin_out.ch0_pin_d, 1'b1)
		wr(OFF_LEVEL, 32'hF);
		`CHK(pin_out.ch0_pin_b, 1'b1)
		`CHK(pin_out.ch0_pin_d, 1'b0)
		`CHK(pin_out.ch0_pin_c, 1'b1)
		wr(OFF_LEVEL, 32'h3);
		wr(OFF_BUFC0, 32'h9);
		wr(OFF_BUFD0, 32'h5);
		wr(OFF_BUFC1, 32'h0);
		wr(OFF_BUFD1, 32'h8);
		wr(OFF_MODE, 32'h20);
		wr(OFF_START, 32'h3);
		repeat (12) @(posedge hclk);
		rd(OFF_DUTY1, 32'h5);
		window();
		`CHK(hi[6], 8)
		wr(OFF_MODE, 32'h40);
		@(posedge hclk);
		fault <= 1'b1;
		repeat (4) @(posedge hclk);
		#1;
		`CHK(pin_oe, 8'h00)
		rd(OFF_DISABLE, 32'hFF);
		final_report();
	end
endmodule : reset_sync_three_phase_pwm_tb
bind reset_sync_three_phase_pwm reset_sync_three_phase_pwm_assertions
	u_reset_sync_three_phase_pwm_assertions (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.fast_osc_clock(fast_osc_clock), .cutoff_interrupt_pin(cutoff_interrupt_pin),
	.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .count_running(count_running));
